// [verilog/hdr_consts.vh]
// Constants for the hub descriptor content logic: field values,
// layout offsets and total lengths of the configuration response.
// Assumes it is included by bare name from the design files only.
`ifndef HDR_CONSTS_VH
`define HDR_CONSTS_VH

// ****************************************************************
// Descriptor lengths and types
// ****************************************************************
`define HDR_CFG_LEN 8'h09
`define HDR_CFG_TYPE 8'h02
`define HDR_OSC_TYPE 8'h07
`define HDR_INTF_LEN 8'h09
`define HDR_INTF_TYPE 8'h04
`define HDR_EP_LEN 8'h07
`define HDR_EP_TYPE 8'h05
`define HDR_OTG_LEN 8'h03
`define HDR_OTG_TYPE 8'h09

// ****************************************************************
// Field values
// ****************************************************************
`define HDR_ONE_INTF 8'h01
`define HDR_TWO_INTF 8'h02
`define HDR_CFG_VALUE 8'h01
`define HDR_CFG_STR 8'h00
`define HDR_ATTR_BUS 8'ha0
`define HDR_ATTR_SELF 8'he0
`define HDR_INTF_NUM 8'h00
`define HDR_ALT_PRIMARY 8'h00
`define HDR_ALT_MULTI 8'h01
`define HDR_NUM_EP 8'h01
`define HDR_HUB_CLASS 8'h09
`define HDR_HUB_SUBCLASS 8'h00
`define HDR_PROTO_FS 8'h00
`define HDR_PROTO_STT 8'h01
`define HDR_PROTO_MTT 8'h02
`define HDR_INTF_STR 8'h00
`define HDR_EP_ADDR 8'h81
`define HDR_EP_ATTR 8'h03
`define HDR_EP_MPS 16'h0001
`define HDR_IVAL_FS 8'hff
`define HDR_IVAL_HS 8'h0c
`define HDR_OTG_ATTR 8'h01
`define HDR_PAD 8'h00

// ****************************************************************
// Total lengths
// ****************************************************************
`define HDR_TOT_STT 16'h0019
`define HDR_TOT_STT_OTG 16'h001c
`define HDR_TOT_MTT 16'h0029
`define HDR_TOT_MTT_OTG 16'h002f

// ****************************************************************
// Layout offsets within the response
// ****************************************************************
`define HDR_OFS_ATTR 6'd7
`define HDR_OFS_POWER 6'd8
`define HDR_SEG_INTF 6'd9
`define HDR_SEG_EP 6'd18
`define HDR_SEG_ALT 6'd25
`define HDR_SEG_EP2 6'd34
`define HDR_SEG_END 6'd41

`endif

// [verilog/hdr_byte_rom.v]
// Descriptor byte store: returns the configuration response byte at
// a given offset, registered. Mode inputs are held stable by the
// sequencer for the whole response.
`timescale 1ns/1ps
`include "hdr_consts.vh"

module hdr_byte_rom (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Lookup
    input wire rd_en,
    input wire [5:0] addr,
    output reg [7:0] q,
    // Mode
    input wire other_speed,
    input wire high_speed,
    input wire multi,
    input wire otg_en,
    input wire self_powered,
    input wire [7:0] max_power,
    input wire [15:0] total_len
);

    // Packet size held as a constant so its two bytes can be selected
    localparam [15:0] EP_MPS = `HDR_EP_MPS;

    // ****************************************************************
    // Decoding shared by the two interface and endpoint copies
    // ****************************************************************
    function [7:0] intf_byte;
        input [5:0] i;
        input alt;
        input [7:0] proto;
        begin
            case (i)
                6'd0: intf_byte = `HDR_INTF_LEN;
                6'd1: intf_byte = `HDR_INTF_TYPE;
                6'd2: intf_byte = `HDR_INTF_NUM;
                6'd3: intf_byte = alt ? `HDR_ALT_MULTI : `HDR_ALT_PRIMARY;
                6'd4: intf_byte = `HDR_NUM_EP;
                6'd5: intf_byte = `HDR_HUB_CLASS;
                6'd6: intf_byte = `HDR_HUB_SUBCLASS;
                6'd7: intf_byte = proto;
                default: intf_byte = `HDR_INTF_STR;
            endcase
        end
    endfunction

    function [7:0] ep_byte;
        input [5:0] i;
        input hs;
        begin
            case (i)
                6'd0: ep_byte = `HDR_EP_LEN;
                6'd1: ep_byte = `HDR_EP_TYPE;
                6'd2: ep_byte = `HDR_EP_ADDR;
                6'd3: ep_byte = `HDR_EP_ATTR;
                6'd4: ep_byte = EP_MPS[7:0];
                6'd5: ep_byte = EP_MPS[15:8];
                default: ep_byte = hs ? `HDR_IVAL_HS : `HDR_IVAL_FS;
            endcase
        end
    endfunction

    // ****************************************************************
    // Byte selection
    // ****************************************************************
    reg [7:0] next_q;
    reg [5:0] rel;
    reg [7:0] proto;

    // Layout: config, OTG, interface, endpoint, alternate, endpoint
    always @* begin
        next_q = `HDR_PAD;
        rel = addr;
        if (!high_speed) begin
            proto = `HDR_PROTO_FS;
        end else if (multi) begin
            proto = `HDR_PROTO_MTT;
        end else begin
            proto = `HDR_PROTO_STT;
        end
        if (addr < 6'd9) begin
            case (addr)
                6'd0: next_q = `HDR_CFG_LEN;
                6'd1: next_q = other_speed ? `HDR_OSC_TYPE : `HDR_CFG_TYPE;
                6'd2: next_q = total_len[7:0];
                6'd3: next_q = total_len[15:8];
                6'd4: next_q = multi ? `HDR_TWO_INTF : `HDR_ONE_INTF;
                6'd5: next_q = `HDR_CFG_VALUE;
                6'd6: next_q = `HDR_CFG_STR;
                6'd7: next_q = self_powered ? `HDR_ATTR_SELF : `HDR_ATTR_BUS;
                default: next_q = max_power;
            endcase
        end else begin
            if (otg_en) begin
                rel = addr - 6'd3;
            end
            // OTG descriptor sits right after the configuration header
            if (otg_en && addr < 6'd12) begin
                case (addr)
                    6'd9: next_q = `HDR_OTG_LEN;
                    6'd10: next_q = `HDR_OTG_TYPE;
                    default: next_q = `HDR_OTG_ATTR;
                endcase
            end else if (rel < `HDR_SEG_EP) begin
                next_q = intf_byte(rel - `HDR_SEG_INTF, 1'b0, proto);
            end else if (rel < `HDR_SEG_ALT) begin
                next_q = ep_byte(rel - `HDR_SEG_EP, high_speed);
            end else if (multi && rel < `HDR_SEG_EP2) begin
                next_q = intf_byte(rel - `HDR_SEG_ALT, 1'b1, `HDR_PROTO_MTT);
            end else if (multi && rel < `HDR_SEG_END) begin
                next_q = ep_byte(rel - `HDR_SEG_EP2, high_speed);
            end
        end
    end

    // Registered read port
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= 8'h00;
        end else if (ce && rd_en) begin
            q <= next_q;
        end
    end

endmodule

// [verilog/hdr_desc_seq.v]
// Descriptor response sequencer of a four-port hub: streams the
// configuration or other-speed configuration response byte by byte.
// Assumes the endpoint 0 engine, in the same clock domain, decodes
// the control request and pulls bytes with a ready handshake.
`timescale 1ns/1ps
`include "hdr_consts.vh"

module hdr_desc_seq (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Mode straps from hub configuration
    input wire cfg_high_speed,
    input wire cfg_multi_tt,
    input wire cfg_otg_en,
    input wire cfg_self_powered,
    input wire [7:0] cfg_max_power,
    // Request from endpoint 0 engine
    input wire req_start,
    input wire req_other_speed,
    input wire [15:0] req_len,
    // Byte stream back to endpoint 0 engine
    output wire [7:0] byte_data,
    output reg byte_valid,
    output reg byte_last,
    input wire byte_ready,
    // Status
    output reg busy,
    output reg resp_done
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_FETCH = 2'b01;
    localparam [1:0] ST_SEND = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [5:0] idx;
    reg [5:0] next_idx;
    reg [15:0] limit;
    reg [15:0] next_limit;
    reg next_byte_valid;
    reg next_byte_last;
    reg next_busy;
    reg next_resp_done;
    reg rd_en;

    // Mode snapshot, held for the whole response
    reg snap_other;
    reg snap_hs;
    reg snap_multi;
    reg snap_otg;
    reg snap_self;
    reg [7:0] snap_power;
    reg [15:0] snap_total;

    wire live_multi;
    reg [15:0] live_total;
    wire [15:0] live_limit;

    // ****************************************************************
    // Total length of the response
    // ****************************************************************
    // Alternate interface only exists at high speed
    assign live_multi = cfg_multi_tt & cfg_high_speed;

    always @* begin
        case ({live_multi, cfg_otg_en})
            2'b00: live_total = `HDR_TOT_STT;
            2'b01: live_total = `HDR_TOT_STT_OTG;
            2'b10: live_total = `HDR_TOT_MTT;
            default: live_total = `HDR_TOT_MTT_OTG;
        endcase
    end

    // Never return more than the host asked for
    assign live_limit = (req_len < live_total) ? req_len : live_total;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Two cycles per byte: the store read is registered, which keeps
    // the data output straight off a flip-flop at the cost of rate.
    always @* begin
        next_state = state;
        next_idx = idx;
        next_limit = limit;
        next_byte_valid = byte_valid;
        next_byte_last = byte_last;
        next_busy = busy;
        next_resp_done = 1'b0;
        rd_en = 1'b0;
        case (state)
            ST_IDLE: begin
                if (req_start) begin
                    next_idx = 6'd0;
                    next_limit = live_limit;
                    if (live_limit == 16'h0000) begin
                        next_resp_done = 1'b1;
                    end else begin
                        next_busy = 1'b1;
                        next_state = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                rd_en = 1'b1;
                next_byte_valid = 1'b1;
                next_byte_last = ({10'h000, idx} == limit - 16'h0001);
                next_state = ST_SEND;
            end
            ST_SEND: begin
                // Offsets rise by one per accepted byte
                if (byte_ready) begin
                    next_byte_valid = 1'b0;
                    next_byte_last = 1'b0;
                    next_idx = idx + 6'd1;
                    if (byte_last) begin
                        next_busy = 1'b0;
                        next_resp_done = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_FETCH;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_byte_valid = 1'b0;
                next_byte_last = 1'b0;
                next_busy = 1'b0;
            end
        endcase
    end

    // State registers, frozen while ce is low
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            idx <= 6'd0;
            limit <= 16'h0000;
            byte_valid <= 1'b0;
            byte_last <= 1'b0;
            busy <= 1'b0;
            resp_done <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            idx <= next_idx;
            limit <= next_limit;
            byte_valid <= next_byte_valid;
            byte_last <= next_byte_last;
            busy <= next_busy;
            resp_done <= next_resp_done;
        end
    end

    // Snapshot so a strap change mid-response cannot tear the bytes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_other <= 1'b0;
            snap_hs <= 1'b0;
            snap_multi <= 1'b0;
            snap_otg <= 1'b0;
            snap_self <= 1'b0;
            snap_power <= 8'h00;
            snap_total <= 16'h0000;
        end else if (ce && state == ST_IDLE && req_start) begin
            snap_other <= req_other_speed;
            snap_hs <= cfg_high_speed;
            snap_multi <= live_multi;
            snap_otg <= cfg_otg_en;
            snap_self <= cfg_self_powered;
            snap_power <= cfg_max_power;
            snap_total <= live_total;
        end
    end

    // ****************************************************************
    // Byte store
    // ****************************************************************
    hdr_byte_rom i_hdr_byte_rom (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .rd_en(rd_en),
        .addr(idx),
        .q(byte_data),
        .other_speed(snap_other),
        .high_speed(snap_hs),
        .multi(snap_multi),
        .otg_en(snap_otg),
        .self_powered(snap_self),
        .max_power(snap_power),
        .total_len(snap_total)
    );

endmodule

// [testbench/hdr_desc_seq_sva.sv]
// Checker of the sequencer request and stream handshake.
// Assumes bind onto hdr_desc_seq; frozen cycles are not judged.
`timescale 1ns/1ps
module hdr_desc_seq_sva (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Request
    input wire req_start,
    input wire [15:0] req_len,
    // Stream and status
    input wire [7:0] byte_data,
    input wire byte_valid,
    input wire byte_last,
    input wire byte_ready,
    input wire busy,
    input wire resp_done
);
    // ****
    // Properties
    // ****
    // At the edge that ends a frozen stretch the sampled values did not advance over the last cycle
    reg ce_last;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ce_last <= 1'b0;
        end else begin
            ce_last <= ce;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n || !ce || !ce_last);
    // Request taken from idle with bytes to send
    sequence s_take;
        !busy && req_start && req_len != 16'h0000;
    endsequence
    // Final byte handed over
    sequence s_last_acc;
        byte_valid && byte_ready && byte_last;
    endsequence
    a_busy_rise: assert property (s_take |=> busy) else $error("busy late");
    a_first_byte: assert property (s_take |-> ##2 byte_valid) else $error("first byte late");
    a_stall_hold: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data)
        && $stable(byte_last)) else $error("byte moved in stall");
    a_fetch_gap: assert property (byte_valid && byte_ready && !byte_last |=> !byte_valid ##1 byte_valid)
        else $error("next byte timing");
    a_end_resp: assert property (s_last_acc |=> resp_done && !busy && !byte_valid) else $error("no end");
    a_done_pulse: assert property (resp_done |=> !resp_done) else $error("done too long");
    a_zero_len: assert property (!busy && req_start && req_len == 16'h0000 |=> resp_done && !byte_valid)
        else $error("zero length wrong");
    a_valid_busy: assert property (byte_valid |-> busy) else $error("byte while idle");
endmodule
bind hdr_desc_seq hdr_desc_seq_sva i_hdr_desc_seq_sva (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .req_start(req_start), .req_len(req_len), .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_last(byte_last), .byte_ready(byte_ready), .busy(busy), .resp_done(resp_done));

// [testbench/hdr_host_sink.sv]
// Host side sink: takes response bytes into a capture array.
// Assumes the sequencer clock; stall makes ready alternate.
`timescale 1ns/1ps
module hdr_host_sink (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Control from bench
    input wire stall,
    input wire clr,
    // Byte stream
    input wire [7:0] byte_data,
    input wire byte_valid,
    input wire byte_last,
    output reg byte_ready
);
    reg [7:0] mem [0:63];
    integer cnt;
    integer last_at;
    // Capture in arrival order; alternating ready tests hold
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byte_ready <= 1'b0;
            cnt <= 0;
            last_at <= -1;
        end else if (ce) begin
            // Shares the sequencer clock enable, so a freeze takes nothing
            byte_ready <= stall ? ~byte_ready : 1'b1;
            if (clr) begin
                cnt <= 0;
                last_at <= -1;
            end else if (byte_valid && byte_ready) begin
                mem[cnt] <= byte_data;
                cnt <= cnt + 1;
                if (byte_last)
                    last_at <= cnt;
            end
        end
    end
endmodule

// [testbench/hub_descriptor_rom_tb_top.sv]
// Self-checking bench of the descriptor sequencer with a host sink.
// Assumes one 200 MHz clock; ce is high except in the freeze scenario.
`timescale 1ns/1ps
module hub_descriptor_rom_tb_top;
    reg clk_sys, rst_n, ce, hs, mt, otg, sp, os, req_start, stall, clr;
    reg fz;
    reg [7:0] pw;
    reg [15:0] len;
    wire [7:0] byte_data;
    wire byte_valid, byte_last, byte_ready, busy, resp_done;
    integer num_errors, comparisons, n;
    reg [7:0] exp [0:63];
    // ****
    // Instances
    // ****
    hdr_desc_seq i_hdr_desc_seq (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cfg_high_speed(hs),
        .cfg_multi_tt(mt), .cfg_otg_en(otg), .cfg_self_powered(sp), .cfg_max_power(pw),
        .req_start(req_start), .req_other_speed(os), .req_len(len), .byte_data(byte_data),
        .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready), .busy(busy),
        .resp_done(resp_done));
    hdr_host_sink i_hdr_host_sink (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .stall(stall), .clr(clr),
        .byte_data(byte_data), .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready));
    // ****
    // Shared tasks
    // ****
    task chk(input string what, input [15:0] seen, input [15:0] want);
        comparisons = comparisons + 1;
        if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    // Push k bytes of v, first byte highest
    task add(input [71:0] v, input integer k);
        for (int i = k - 1; i >= 0; i--) begin
            exp[n] = v[8*i +: 8];
            n = n + 1;
        end
    endtask
    // Expected image, padded with zeros up to the total length
    task build;
        reg m;
        reg [15:0] tot;
        m = hs & mt;
        tot = m ? (otg ? 16'h002f : 16'h0029) : (otg ? 16'h001c : 16'h0019);
        n = 0;
        add({8'h09, os ? 8'h07 : 8'h02, tot[7:0], tot[15:8], m ? 8'h02 : 8'h01, 16'h0100,
            sp ? 8'he0 : 8'ha0, pw}, 9);
        if (otg)
            add(24'h030901, 3);
        add({56'h09040000010900, hs ? (m ? 8'h02 : 8'h01) : 8'h00, 8'h00}, 9);
        add({48'h070581030100, hs ? 8'h0c : 8'hff}, 7);
        if (m)
            add({72'h090400010109000200}, 9);
        if (m)
            add({48'h070581030100, 8'h0c}, 7);
        while (n < tot)
            add(8'h00, 1);
    endtask
    // One response: request, wait for the end, compare every byte
    task run(input h, t, g, s, o, input [15:0] l, input st);
        integer i, lim;
        @(posedge clk_sys);
        hs <= h;
        mt <= t;
        otg <= g;
        sp <= s;
        os <= o;
        len <= l;
        pw <= l[7:0] ^ 8'h5a;
        stall <= st;
        clr <= 1'b1;
        req_start <= 1'b1;
        @(posedge clk_sys);
        req_start <= 1'b0;
        clr <= 1'b0;
        #1;
        build;
        // Freeze mid-stream: byte 1 must stand and nothing be taken
        if (fz) begin
            repeat (3) @(posedge clk_sys);
            ce <= 1'b0;
            repeat (4) @(posedge clk_sys);
            #1;
            chk("frozen valid", byte_valid, 1);
            chk("frozen byte", byte_data, exp[1]);
            chk("frozen busy", busy, 1);
            chk("frozen count", i_hdr_host_sink.cnt, 1);
            @(posedge clk_sys);
            ce <= 1'b1;
        end
        // Look just after each edge, where the outputs have settled
        for (i = 0; i < 1000 && resp_done !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("resp_done", resp_done, 1);
        lim = (l < n) ? l : n;
        chk("count", i_hdr_host_sink.cnt, lim);
        chk("last", i_hdr_host_sink.last_at, lim - 1);
        for (i = 0; i < lim; i++)
            chk($sformatf("byte %0d", i), i_hdr_host_sink.mem[i], exp[i]);
    endtask
    // ****
    // Scenarios
    // ****
    task t_fs_other;
        run(0, 1, 0, 0, 1, 16'hffff, 0);
    endtask
    task t_hs_single_otg;
        run(1, 0, 1, 1, 0, 16'hffff, 1);
    endtask
    task t_hs_multi;
        run(1, 1, 0, 1, 1, 16'h0029, 1);
    endtask
    task t_multi_otg_cut;
        run(1, 1, 1, 0, 1, 16'h002e, 0);
    endtask
    task t_one_byte;
        run(1, 0, 0, 0, 1, 16'h0001, 1);
    endtask
    task t_ce_freeze;
        fz = 1'b1;
        run(0, 0, 0, 1, 0, 16'h0009, 0);
        fz = 1'b0;
    endtask
    task t_zero;
        run(0, 0, 1, 1, 1, 16'h0000, 0);
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****
    // Clock, main sequence, watchdog
    // ****
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, hs, mt, otg, sp, os, req_start, stall, clr} = 9'h000;
        ce = 1'b1;
        fz = 1'b0;
        pw = 8'h00;
        len = 16'h0000;
        num_errors = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_fs_other;
        t_hs_single_otg;
        t_hs_multi;
        t_multi_otg_cut;
        t_one_byte;
        t_ce_freeze;
        t_zero;
        end_of_test;
    end
    // Whole run needs under 2000 cycles; cut hangs at 20000
    initial begin
        #100000;
        num_errors = num_errors + 1;
        end_of_test;
    end
endmodule
